// *** lvdsr_pkg.sv ***
// Constants, register map and field layout of the LVDS deserializer receiver.
package lvdsr_pkg;
   // Channel count and deserialization factor.
   localparam int NUM_CH = 44;
   localparam int DES_FACTOR = 10;
   localparam int WORD_W = NUM_CH * DES_FACTOR;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(DES_FACTOR - 1);
   localparam bit IS_DDR = (DES_FACTOR == 2);

   // Capture phase: sixteen steps of 22.50 degrees, kept in hundredths of a degree.
   localparam int PHASE_W = 4;
   localparam int PHASE_STEP_CDEG = 2250;
   localparam int CENTER_SHIFT_CDEG = 9000;
   localparam logic [PHASE_W-1:0] CENTER_STEPS = PHASE_W'(CENTER_SHIFT_CDEG / PHASE_STEP_CDEG);
   localparam logic [PHASE_W-1:0] SYNC_COMP_STEPS = 4'h1;

   // Per-channel skew compensation taps.
   localparam int DLY_W = 2;
   localparam int DLY_TAPS = 4;
   localparam int CH_IDX_W = 6;

   // Phase-compensation FIFO.
   localparam int FIFO_AW = 2;
   localparam int PTR_W = FIFO_AW + 1;
   localparam int FIFO_DEPTH = 4;

   // Self-reset pulse length after a lost lock.
   localparam int CLK_PERIOD_NS = 100;
   localparam int SELF_RST_TIME_NS = 1000;
   localparam int SELF_RST_CYC_I = (SELF_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SELF_RST_CYC = 4'(SELF_RST_CYC_I);

   // Register map.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_PHASE = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_DPA = 8'h0C;

   // Control register fields.
   localparam int CTRL_PLL_RST = 0;
   localparam int CTRL_PLL_EN = 1;
   localparam int CTRL_SELF_RST = 2;
   localparam int CTRL_CENTER = 3;
   localparam int CTRL_SRC_SYNC = 4;
   localparam int CTRL_DPA_EN = 5;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h12;

   // Status register fields.
   localparam int STAT_LOCKED = 0;
   localparam int STAT_OVF = 1;
   localparam int STAT_EMPTY = 2;

   // Skew register fields.
   localparam int DPA_CH_LSB = 0;
   localparam int DPA_DLY_LSB = 8;
endpackage

// *** lvdsr_receiver.sv ***
// Multi-channel source-synchronous LVDS deserializer receiver with APB control.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Deserializing starts on the third link clock edge after lock, once two sync flops pass it; earlier bits ignored.
// - Each channel collects factor consecutive serial bits into one parallel word.
// - Output bus is channels times factor wide, one contiguous slice per channel.
// - With factor two, double-rate registers capture one bit on each edge.
// - Data reset asynchronously clears the link and output data path, not the control registers, status or PLL control.
// - PLL reset input drives the PLL reset; shared instances tie it together.
// - PLL enable input gates the PLL enable; shared instances tie it together.
// - Lock output reports PLL lock, same as transmitter lock when shared.
// - Non-DPA capture phase selectable in sixteen steps of 22.50 degrees.
// - Center alignment adds a 90 degree shift to the capture clock outside DPA mode.
// - Self-reset pulses the PLL reset whenever lock is lost.
// - In DPA mode parallel data passes a phase-compensation FIFO to core clock.
// - Outside DPA mode, source-synchronous mode adds phase compensation matching pin clock-to-data.
// - DPA mode compensates per-channel lane skew.
// - Parallel words are registered on the output clock before reaching the core.
module lvdsr_receiver
   import lvdsr_pkg::*;
(
   // APB register port
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link
   input wire logic lclk,
   input wire logic [NUM_CH-1:0] serial_in,
   // PLL control and status
   input wire logic pll_areset_in,
   input wire logic pll_enable_in,
   input wire logic pll_lock_in,
   output logic pll_areset,
   output logic pll_enable,
   output logic [PHASE_W-1:0] pll_phase,
   output logic rx_locked,
   // Data reset
   input wire logic data_reset,
   // Parallel output to the core
   output logic [WORD_W-1:0] rx_word,
   output logic rx_valid
);

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [PHASE_W-1:0] phase;
      logic [NUM_CH-1:0][DLY_W-1:0] dly;
      logic [CH_IDX_W-1:0] dpa_sel;
      logic ovf;
      logic [31:0] rdata;
      logic lock_s1;
      logic lock_s2;
      logic lock_prev;
      logic arst_s1;
      logic arst_s2;
      logic en_s1;
      logic en_s2;
      logic ovf_s1;
      logic ovf_s2;
      logic ovf_s3;
      logic [3:0] self_cnt;
      logic pll_rst;
      logic pll_en;
      logic [PHASE_W-1:0] pll_ph;
   } lvdsr_cfg_t;

   typedef struct packed {
      logic [PTR_W-1:0] rd_bin;
      logic [PTR_W-1:0] rd_gray;
      logic [PTR_W-1:0] ws1;
      logic [PTR_W-1:0] ws2;
      logic [WORD_W-1:0] word;
      logic valid;
   } lvdsr_core_t;

   typedef struct packed {
      logic lock_s1;
      logic lock_s2;
      logic dpa_s1;
      logic dpa_s2;
      logic dpa_s3;
      logic [NUM_CH-1:0][DLY_W-1:0] dly;
      logic [NUM_CH-1:0][DLY_TAPS-1:0] hist;
      logic [NUM_CH-1:0][DES_FACTOR-1:0] shift;
      logic [CNT_W-1:0] bitcnt;
      logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
      logic [PTR_W-1:0] wr_bin;
      logic [PTR_W-1:0] wr_gray;
      logic [PTR_W-1:0] rs1;
      logic [PTR_W-1:0] rs2;
      logic ovf_tgl;
   } lvdsr_link_t;

   lvdsr_cfg_t c;
   lvdsr_cfg_t next_c;
   lvdsr_core_t q;
   lvdsr_core_t next_q;
   lvdsr_link_t l;
   lvdsr_link_t next_l;
   logic [NUM_CH-1:0] ddr_fall;
   logic drst_n;

   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      for (int i = PTR_W - 1; i >= 0; i--)
      begin
         b[i] = ^(g >> i);
      end
      gray2bin = b;
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == ADDR_CTRL) || (a == ADDR_PHASE) || (a == ADDR_STATUS) || (a == ADDR_DPA);
   endfunction

   // The data path is cleared by either reset, the PLL control only by presetn.
   assign drst_n = presetn & ~data_reset;

   // ---------------- Control and APB, pclk domain ----------------
   always_comb
   begin
      logic acc_wr;
      logic ovf_evt;
      logic [CH_IDX_W-1:0] ch;
      logic [PHASE_W-1:0] ph;
      acc_wr = psel & penable & pwrite;
      ovf_evt = c.ovf_s2 ^ c.ovf_s3;
      ch = pwdata[DPA_CH_LSB +: CH_IDX_W];
      ph = '0;
      next_c = c;
      next_c.lock_s1 = pll_lock_in;
      next_c.lock_s2 = c.lock_s1;
      next_c.lock_prev = c.lock_s2;
      next_c.arst_s1 = pll_areset_in;
      next_c.arst_s2 = c.arst_s1;
      next_c.en_s1 = pll_enable_in;
      next_c.en_s2 = c.en_s1;
      next_c.ovf_s1 = l.ovf_tgl;
      next_c.ovf_s2 = c.ovf_s1;
      next_c.ovf_s3 = c.ovf_s2;

      if (psel && !penable)
      begin
         unique case (paddr)
            ADDR_CTRL: next_c.rdata = 32'(c.ctrl);
            ADDR_PHASE: next_c.rdata = 32'(c.phase);
            ADDR_STATUS:
            begin
               next_c.rdata = 32'h0;
               next_c.rdata[STAT_LOCKED] = c.lock_s2;
               next_c.rdata[STAT_OVF] = c.ovf;
               next_c.rdata[STAT_EMPTY] = (bin2gray(q.rd_bin) == q.ws2);
            end
            ADDR_DPA:
            begin
               next_c.rdata = 32'h0;
               next_c.rdata[DPA_CH_LSB +: CH_IDX_W] = c.dpa_sel;
               if (c.dpa_sel < CH_IDX_W'(NUM_CH))
               begin
                  next_c.rdata[DPA_DLY_LSB +: DLY_W] = c.dly[c.dpa_sel];
               end
            end
            default: next_c.rdata = 32'h0;
         endcase
      end

      if (acc_wr)
      begin
         unique case (paddr)
            ADDR_CTRL: next_c.ctrl = pwdata[CTRL_W-1:0];
            ADDR_PHASE: next_c.phase = pwdata[PHASE_W-1:0];
            ADDR_STATUS:
            begin
               if (pwdata[STAT_OVF])
               begin
                  next_c.ovf = 1'b0;
               end
            end
            ADDR_DPA:
            begin
               next_c.dpa_sel = ch;
               if (ch < CH_IDX_W'(NUM_CH))
               begin
                  next_c.dly[ch] = pwdata[DPA_DLY_LSB +: DLY_W];
               end
            end
            default: next_c.ovf = c.ovf;
         endcase
      end
      // A new overflow in the clearing cycle survives the clear.
      if (ovf_evt)
      begin
         next_c.ovf = 1'b1;
      end

      if (c.ctrl[CTRL_SELF_RST] && c.lock_prev && !c.lock_s2)
      begin
         next_c.self_cnt = SELF_RST_CYC;
      end
      else if (c.self_cnt != 4'h0)
      begin
         next_c.self_cnt = c.self_cnt - 4'h1;
      end

      next_c.pll_rst = c.arst_s2 | c.ctrl[CTRL_PLL_RST] | (next_c.self_cnt != 4'h0);
      next_c.pll_en = c.en_s2 & c.ctrl[CTRL_PLL_EN];
      ph = c.phase;
      if (c.ctrl[CTRL_CENTER])
      begin
         ph = ph + CENTER_STEPS;
      end
      if (c.ctrl[CTRL_SRC_SYNC])
      begin
         ph = ph + SYNC_COMP_STEPS;
      end
      // Phase selection belongs to non-DPA mode; DPA picks its own sampling point.
      next_c.pll_ph = c.ctrl[CTRL_DPA_EN] ? '0 : ph;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c <= '0;
         c.ctrl <= CTRL_RESET;
      end
      else
      begin
         c <= next_c;
      end
   end

   // ---------------- Parallel output, pclk domain ----------------
   always_comb
   begin
      next_q = q;
      next_q.ws1 = l.wr_gray;
      next_q.ws2 = q.ws1;
      next_q.valid = 1'b0;
      if (bin2gray(q.rd_bin) != q.ws2)
      begin
         next_q.rd_bin = q.rd_bin + PTR_W'(1);
         next_q.word = c.lock_s2 ? l.mem[q.rd_bin[FIFO_AW-1:0]] : '0;
         next_q.valid = c.lock_s2;
      end
      if (!c.lock_s2)
      begin
         next_q.word = '0;
      end
      next_q.rd_gray = bin2gray(next_q.rd_bin);
   end

   always_ff @(posedge pclk or negedge drst_n)
   begin
      if (!drst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   // ---------------- Link side, lclk domain ----------------
   generate
      if (IS_DDR)
      begin : g_ddr
         always_ff @(negedge lclk or negedge drst_n)
         begin
            if (!drst_n)
            begin
               ddr_fall <= '0;
            end
            else
            begin
               ddr_fall <= serial_in;
            end
         end
      end
      else
      begin : g_sdr
         assign ddr_fall = '0;
      end
   endgenerate

   always_comb
   begin
      logic [NUM_CH-1:0][DLY_TAPS-1:0] h;
      logic [NUM_CH-1:0][DES_FACTOR-1:0] s;
      logic [WORD_W-1:0] w;
      logic push;
      logic [PTR_W-1:0] rbin;
      h = l.hist;
      s = l.shift;
      w = '0;
      push = 1'b0;
      rbin = gray2bin(l.rs2);
      next_l = l;
      next_l.lock_s1 = pll_lock_in;
      next_l.lock_s2 = l.lock_s1;
      next_l.dpa_s1 = c.ctrl[CTRL_DPA_EN];
      next_l.dpa_s2 = l.dpa_s1;
      next_l.dpa_s3 = l.dpa_s2;
      next_l.rs1 = q.rd_gray;
      next_l.rs2 = l.rs1;
      // Skew settings are taken when DPA turns on; software holds them still meanwhile.
      if (l.dpa_s2 && !l.dpa_s3)
      begin
         next_l.dly = c.dly;
      end

      if (!l.lock_s2)
      begin
         next_l.bitcnt = '0;
      end
      else
      begin
         for (int ch = 0; ch < NUM_CH; ch++)
         begin
            h[ch] = {l.hist[ch][DLY_TAPS-2:0], serial_in[ch]};
            s[ch] = {l.shift[ch][DES_FACTOR-2:0],
               l.dpa_s2 ? h[ch][l.dly[ch]] : serial_in[ch]};
            if (IS_DDR)
            begin
               w[ch*DES_FACTOR +: DES_FACTOR] = DES_FACTOR'({ddr_fall[ch], serial_in[ch]});
            end
            else
            begin
               w[ch*DES_FACTOR +: DES_FACTOR] = s[ch];
            end
         end
         next_l.hist = h;
         next_l.shift = s;
         push = IS_DDR || (l.bitcnt == LAST_BIT);
         next_l.bitcnt = (l.bitcnt == LAST_BIT) ? '0 : l.bitcnt + CNT_W'(1);
      end

      if (push)
      begin
         if ((l.wr_bin - rbin) == PTR_W'(FIFO_DEPTH))
         begin
            next_l.ovf_tgl = ~l.ovf_tgl;
         end
         else
         begin
            next_l.mem[l.wr_bin[FIFO_AW-1:0]] = w;
            next_l.wr_bin = l.wr_bin + PTR_W'(1);
         end
      end
      next_l.wr_gray = bin2gray(next_l.wr_bin);
   end

   always_ff @(posedge lclk or negedge drst_n)
   begin
      if (!drst_n)
      begin
         l <= '0;
      end
      else
      begin
         l <= next_l;
      end
   end

   // ---------------- Outputs ----------------
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);
   assign prdata = c.rdata;
   assign pll_areset = c.pll_rst;
   assign pll_enable = c.pll_en;
   assign pll_phase = c.pll_ph;
   assign rx_locked = c.lock_s2;
   assign rx_word = q.word;
   assign rx_valid = q.valid;

endmodule

`default_nettype wire

// *** lvdsr_props.sv ***
// Port-level assertions for the LVDS receiver.
`timescale 1ns/100ps
`default_nettype none
module lvdsr_props
   import lvdsr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // PLL side
   input wire logic pll_areset_in,
   input wire logic pll_enable_in,
   input wire logic pll_lock_in,
   input wire logic pll_areset,
   input wire logic pll_enable,
   input wire logic rx_locked,
   // Data side
   input wire logic data_reset,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic rx_valid
);
   logic [3:0] hi_cnt;
   logic [4:0] lo_cnt;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Run lengths let the self-reset pulse be measured without a long repetition.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hi_cnt <= 4'h0;
         lo_cnt <= 5'h00;
      end
      else
      begin
         hi_cnt <= pll_areset ? hi_cnt + {3'h0, hi_cnt != 4'hF} : 4'h0;
         lo_cnt <= pll_areset_in ? 5'h00 : lo_cnt + {4'h0, lo_cnt != 5'h1F};
      end
   end
   property p_areset_follow;
      pll_areset_in [*3] |=> pll_areset;
   endproperty
   a_areset_follow: assert property (p_areset_follow) else $error("reset lost");
   property p_enable_gate;
      (!pll_enable_in) [*3] |=> !pll_enable;
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("enable not gated");
   property p_lock_follow;
      $stable(pll_lock_in) [*3] |=> rx_locked == $past(pll_lock_in);
   endproperty
   a_lock_follow: assert property (p_lock_follow) else $error("lock wrong");
   property p_dreset_zero;
      data_reset |-> rx_word == '0 && !rx_valid;
   endproperty
   a_dreset_zero: assert property (p_dreset_zero) else $error("data reset ignored");
   property p_unlock_zero;
      (!pll_lock_in) [*8] |-> rx_word == '0;
   endproperty
   a_unlock_zero: assert property (p_unlock_zero) else $error("word while unlocked");
   property p_valid_pulse;
      rx_valid |=> !rx_valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
   property p_word_hold;
      $changed(rx_word) && rx_word != '0 |-> rx_valid;
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word changed alone");
   property p_selfrst;
      $fell(pll_areset) && lo_cnt > 5'h14 |-> hi_cnt == 4'hA;
   endproperty
   a_selfrst: assert property (p_selfrst) else $error("self reset length");
endmodule
bind lvdsr_receiver lvdsr_props i_lvdsr_props (.pclk, .presetn, .pll_areset_in, .pll_enable_in,
   .pll_lock_in, .pll_areset, .pll_enable, .rx_locked, .data_reset, .rx_word, .rx_valid);
`default_nettype wire

// *** lvdsr_tx_model.sv ***
// Remote transmitter model: frames leave MSB first, one bit per link clock edge.
`timescale 1ns/100ps
`default_nettype none
module lvdsr_tx_model
   import lvdsr_pkg::*;
(
   // Link clock and lock
   input wire logic lclk,
   input wire logic locked,
   // Frame source
   input wire logic [WORD_W-1:0] frame,
   output logic [15:0] frame_idx,
   // Lanes
   output logic [NUM_CH-1:0] serial_in
);
   logic [WORD_W-1:0] shreg;
   logic ph = 1'b0;
   int cnt;
   int msb;
   assign msb = DES_FACTOR - 1 - (cnt - 1) % DES_FACTOR;
   always @(posedge lclk)
   begin
      ph <= ~ph;
      if (!locked)
      begin
         cnt <= 0;
         frame_idx <= 16'h0000;
         // Junk toggles every edge, so a capture that starts early cannot match.
         serial_in <= {NUM_CH/4{4'hA}} ^ {NUM_CH{ph}};
      end
      else
      begin
         cnt <= cnt + 1;
         if (cnt >= 1 && msb == DES_FACTOR - 1)
         begin
            shreg <= frame;
            frame_idx <= frame_idx + 16'h0001;
         end
         for (int k = 0; k < NUM_CH; k++)
            if (cnt >= 1)
               serial_in[k] <= (msb == 9) ? frame[k*10+msb] : shreg[k*10+msb];
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the LVDS receiver with random frames.
`timescale 1ns/100ps
`default_nettype none
module tb import lvdsr_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lclk, er;
   logic pll_areset_in, pll_enable_in, pll_lock_in, pll_areset, pll_enable, rx_locked;
   logic data_reset, rx_valid;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NUM_CH-1:0] serial_in;
   logic [PHASE_W-1:0] pll_phase;
   logic [WORD_W-1:0] rx_word, frame;
   logic [15:0] frame_idx;
   logic [31:0] seed = 32'h00000035;
   int fail_count = 0;
   int tests_run = 0;
   int hi;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [WORD_W-1:0] gen(input logic [15:0] j);
      logic [31:0] s;
      logic [447:0] w;
      s = 32'h00000035 + {16'h0000, j};
      w = '0;
      for (int i = 0; i < 14; i++)
         w = {w[415:0], xs(s + i)};
      // A word of all ones is the hard case for a missed first bit.
      if (j == 16'h0001)
         w = '1;
      return w[WORD_W-1:0];
   endfunction
   function automatic logic [PHASE_W-1:0] exp_phase(input logic [3:0] p, input logic [2:0] m);
      if (m[2])
         return 4'h0;
      return p + (m[0] ? 4'h4 : 4'h0) + (m[1] ? 4'h1 : 4'h0);
   endfunction
   lvdsr_receiver i_lvdsr_receiver (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .lclk, .serial_in, .pll_areset_in, .pll_enable_in,
      .pll_lock_in, .pll_areset, .pll_enable, .pll_phase, .rx_locked, .data_reset, .rx_word,
      .rx_valid);
   lvdsr_tx_model i_lvdsr_tx_model (.lclk, .locked(pll_lock_in), .frame, .frame_idx, .serial_in);
   assign frame = gen(frame_idx);
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial
   begin
      lclk = 1'b0;
      #7.3;
      // This clock stands in for an external PLL, which is only legal with a factor of four or more.
      forever #24 lclk = ~lclk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t got %0h exp %0h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n == 0 || (pready !== 1'b1 && n < 20); n++)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 20)
      begin
         chk(1'b0, 1'b1);
         complete_run();
      end
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
      chk(er, e);
   endtask
   task automatic recv(input int n, input logic skew);
      int t;
      logic [WORD_W-1:0] e;
      logic [WORD_W-1:0] p;
      for (int k = 0; k < n; k++)
      begin
         for (t = 0; t == 0 || (rx_valid !== 1'b1 && t < 60); t++)
            @(posedge pclk);
         if (t >= 60)
         begin
            chk(1'b0, 1'b1);
            complete_run();
         end
         e = gen(16'(k));
         p = gen(16'(k - 1));
         // One tap of skew on lane 0 brings in the last bit of the previous frame first.
         if (skew)
            e[DES_FACTOR-1:0] = {p[0], e[DES_FACTOR-1:1]};
         // The tap history is stale at relock, so the first skewed word is not predictable.
         if (!skew || k > 0)
            chk(rx_word, e);
      end
   endtask
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, pll_areset_in, pll_lock_in, data_reset} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pll_enable_in = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk($bits(rx_word), NUM_CH * DES_FACTOR);
      rdchk(ADDR_CTRL, 32'h00000012, 1'b0);
      rdchk(ADDR_STATUS, 32'h00000004, 1'b0);
      rdchk(8'h10, 32'h00000000, 1'b1);
      chk(pll_enable, 1'b1);
      pll_enable_in <= 1'b0;
      pll_areset_in <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(pll_enable, 1'b0);
      chk(pll_areset, 1'b1);
      pll_enable_in <= 1'b1;
      pll_areset_in <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(pll_areset, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         apb(1'b1, ADDR_PHASE, 32'(i));
         apb(1'b1, ADDR_CTRL, {26'h0, seed[2:0], 3'h2});
         repeat (3) @(posedge pclk);
         chk(pll_phase, exp_phase(4'(i), seed[2:0]));
      end
      apb(1'b1, ADDR_CTRL, 32'h00000012);
      pll_lock_in <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(rx_locked, 1'b1);
      recv(12, 1'b0);
      data_reset <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(rx_word, '0);
      chk(rx_locked, 1'b1);
      data_reset <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h00000016);
      pll_lock_in <= 1'b0;
      for (hi = 0; hi < 12 && pll_areset !== 1'b1; hi++)
         @(posedge pclk);
      if (hi >= 12)
      begin
         chk(1'b0, 1'b1);
         complete_run();
      end
      for (hi = 0; hi < 20 && pll_areset === 1'b1; hi++)
         @(posedge pclk);
      chk(WORD_W'(hi), 10);
      if (hi >= 20)
         complete_run();
      chk(rx_word, '0);
      pll_areset_in <= 1'b1;
      repeat (4) @(posedge pclk);
      pll_areset_in <= 1'b0;
      apb(1'b1, ADDR_DPA, 32'h00000100);
      rdchk(ADDR_DPA, 32'h00000100, 1'b0);
      apb(1'b1, ADDR_DPA, 32'h00000232);
      rdchk(ADDR_DPA, 32'h00000032, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h00000032);
      pll_lock_in <= 1'b1;
      recv(7, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
